/* pkg/qenc_pkg.sv */
// qenc_pkg: register map, field positions and reset values of the encoder
`default_nettype none
package qenc_pkg;
  localparam int unsigned POS_W = 32;
  localparam int unsigned VEL_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_POS     = 8'h08;
  localparam logic [7:0] OFS_MAXPOS  = 8'h0c;
  localparam logic [7:0] OFS_PERIOD  = 8'h10;
  localparam logic [7:0] OFS_VELACC  = 8'h14;
  localparam logic [7:0] OFS_VELCAP  = 8'h18;
  localparam logic [7:0] OFS_RAWINT  = 8'h1c;
  localparam logic [7:0] OFS_INTMASK = 8'h20;
  localparam logic [7:0] OFS_MSKINT  = 8'h24;
  localparam logic [7:0] OFS_INTCLR  = 8'h28;
  // control register fields
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_BOTH     = 1;
  localparam int unsigned CTRL_IDXRST   = 2;
  localparam int unsigned CTRL_STEPDIR  = 3;
  localparam int unsigned CTRL_SWAP     = 4;
  localparam int unsigned CTRL_VELEN    = 5;
  localparam int unsigned CTRL_DIV_LSB  = 8;
  localparam int unsigned CTRL_W        = 11;
  // status register fields
  localparam int unsigned STAT_DIR      = 0;
  localparam int unsigned STAT_ERR      = 1;
  // event bits in raw, mask, masked and clear registers
  localparam int unsigned EV_INDEX      = 0;
  localparam int unsigned EV_TIMER      = 1;
  localparam int unsigned EV_DIR        = 2;
  localparam int unsigned EV_ERROR      = 3;
  localparam int unsigned EV_N          = 4;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST  = 11'h000;
  localparam logic [POS_W-1:0]  MAXPOS_RST = 32'hffffffff;
  localparam logic [31:0]       PERIOD_RST = 32'h00000001;
endpackage
`default_nettype wire

/* verilog/qenc_sync.sv */
// qenc_sync: three-flop pin synchroniser with agreement filter
`default_nettype none
module qenc_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      lvl_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // chain; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // change accepted only once second and third stage agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lvl_o <= 1'b0;
    end else if (ce_i && (s2_r == s3_r)) begin
      lvl_o <= s3_r;
    end
  end
endmodule
`default_nettype wire

/* verilog/qenc_core.sv */
// qenc_core: quadrature encoder position/velocity unit with wishbone slave
// Operation
// - phase mode and step/direction mode offered
// - step edge moves one, direction level signs
// - count first channel or both channels
// - optional swap of the two inputs
// - index resets position when enabled
// - maximum limits position, reverse index loads it
// - timer periods accumulate pulses as velocity
// - running and previous-period counts readable
// - velocity works only while unit enabled
// - four events: index, timer, direction, error
// - per-source mask gates interrupt output
// - clear write drops only selected sources
// - direction held while stopped, forward/reverse
// - both inputs changing in phase mode flags phase error
// - disable stops decoding and velocity
// - software may write the position
// - predivider 1 to 128 before velocity
// - period end saves and clears accumulator
//
// Chosen here: the placing of the registers and the Wishbone register port.
`default_nettype none
module qenc_core (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        phase_input_first_i,
  input  wire logic        phase_input_second_i,
  input  wire logic        index_i,
  output logic             irq_o,
  output logic             dir_o,
  output logic             err_o
);
  localparam int unsigned PW = qenc_pkg::POS_W;
  localparam int unsigned VW = qenc_pkg::VEL_W;
  localparam int unsigned NE = qenc_pkg::EV_N;

  logic [qenc_pkg::CTRL_W-1:0] ctrl_r;
  logic [PW-1:0]  pos_r;
  logic [PW-1:0]  maxpos_r;
  logic [31:0]    period_r;
  logic [31:0]    tmr_r;
  logic [VW-1:0]  velacc_r;
  logic [VW-1:0]  velcap_r;
  logic [6:0]     div_r;
  logic [NE-1:0]  raw_r;
  logic [NE-1:0]  mask_r;
  logic           dir_r;
  logic           err_r;
  logic           a_q;
  logic           b_q;
  logic           idx_q;
  logic           a_d_r;
  logic           b_d_r;
  logic           idx_d_r;

  // wiring of control fields
  logic enable;
  logic both;
  logic idxrst;
  logic stepdir;
  logic swap;
  logic velen;
  logic [2:0] divsel;
  assign enable  = ctrl_r[qenc_pkg::CTRL_ENABLE];
  assign both    = ctrl_r[qenc_pkg::CTRL_BOTH];
  assign idxrst  = ctrl_r[qenc_pkg::CTRL_IDXRST];
  assign stepdir = ctrl_r[qenc_pkg::CTRL_STEPDIR];
  assign swap    = ctrl_r[qenc_pkg::CTRL_SWAP];
  assign velen   = ctrl_r[qenc_pkg::CTRL_VELEN];
  assign divsel  = ctrl_r[qenc_pkg::CTRL_DIV_LSB +: 3];

  // pins cross into clk_i through the three-flop filter
  logic [2:0] pin_raw;
  logic [2:0] pin_syn;
  assign pin_raw = {index_i, phase_input_second_i, phase_input_first_i};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      qenc_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .pin_i   (pin_raw[gi]),
        .lvl_o   (pin_syn[gi])
      );
    end
  endgenerate

  // swap happens before any decoding in both modes
  assign a_q   = swap ? pin_syn[1] : pin_syn[0];
  assign b_q   = swap ? pin_syn[0] : pin_syn[1];
  // index is never swapped; it has no partner line
  assign idx_q = pin_syn[2];

  // previous levels for edge detection
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_d_r   <= 1'b0;
      b_d_r   <= 1'b0;
      idx_d_r <= 1'b0;
    end else if (ce_i) begin
      a_d_r   <= a_q;
      b_d_r   <= b_q;
      idx_d_r <= idx_q;
    end
  end

  // decode: one step per counted edge, with its sign
  logic a_ed;
  logic b_ed;
  logic step;
  logic fwd;
  logic perr;
  logic idx_rise;
  always_comb begin
    a_ed     = a_q ^ a_d_r;
    b_ed     = b_q ^ b_d_r;
    idx_rise = enable && idx_q && !idx_d_r;
    perr     = 1'b0;
    step     = 1'b0;
    fwd      = dir_r;
    if (!enable) begin
      step = 1'b0;
    end else if (stepdir) begin
      // b carries the direction level, a the step clock
      step = a_ed;
      fwd  = b_q;
    end else if (a_ed && b_ed) begin
      perr = 1'b1;
    end else if (a_ed) begin
      // a leading b is forward
      step = 1'b1;
      fwd  = a_q ^ b_q;
    end else if (b_ed) begin
      step = both;
      fwd  = ~(a_q ^ b_q);
    end
  end

  // bus decode; single-cycle ack, dropped the cycle after
  logic acc;
  logic wr;
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i;

  // byte-lane merge of write data onto a current value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // control write merged at full width, then cut to the field width;
  // upper lanes of the word carry no state
  logic [31:0] ctrl_wr;
  assign ctrl_wr = merge({21'h0, ctrl_r}, wb_dat_i, wb_sel_i);

  // control, limit, period and mask registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r   <= qenc_pkg::CTRL_RST;
      maxpos_r <= qenc_pkg::MAXPOS_RST;
      period_r <= qenc_pkg::PERIOD_RST;
      mask_r   <= '0;
    end else if (ce_i && wr) begin
      if (wb_adr_i == qenc_pkg::OFS_CTRL) begin
        ctrl_r <= ctrl_wr[qenc_pkg::CTRL_W-1:0];
      end
      if (wb_adr_i == qenc_pkg::OFS_MAXPOS) begin
        maxpos_r <= merge(maxpos_r, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == qenc_pkg::OFS_PERIOD) begin
        // zero is illegal; keep at least one cycle per period
        period_r <= merge(period_r, wb_dat_i, wb_sel_i) |
                    qenc_pkg::PERIOD_RST;
      end
      if (wb_adr_i == qenc_pkg::OFS_INTMASK) begin
        mask_r <= wb_dat_i[NE-1:0];
      end
    end
  end

  // position integrator; software write wins over a step
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pos_r <= '0;
    end else if (ce_i) begin
      if (wr && wb_adr_i == qenc_pkg::OFS_POS) begin
        pos_r <= merge(pos_r, wb_dat_i, wb_sel_i);
      end else if (idx_rise && idxrst) begin
        // reverse travel wraps to the limit, forward to zero
        pos_r <= fwd ? '0 : maxpos_r;
      end else if (step && fwd) begin
        pos_r <= (pos_r >= maxpos_r) ? '0 : pos_r + 1'b1;
      end else if (step) begin
        pos_r <= (pos_r == '0) ? maxpos_r : pos_r - 1'b1;
      end
    end
  end

  // direction and error indicators; direction holds when idle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dir_r <= 1'b1;
      err_r <= 1'b0;
    end else if (ce_i) begin
      if (step) begin
        dir_r <= fwd;
      end
      if (perr) begin
        err_r <= 1'b1;
        // disabling the unit is the only way to clear the error
      end else if (!enable) begin
        err_r <= 1'b0;
      end
    end
  end

  // predivider: a pulse passes when the low bits wrap
  // divider runs across periods so the ratio holds over long runs
  logic vel_pulse;
  logic [6:0] div_mask;
  assign div_mask  = 7'(({7'h00, 1'b1} << divsel) - 8'h01);
  assign vel_pulse = step && ((div_r & div_mask) == div_mask);

  // velocity timer, accumulator and captured value
  logic vel_run;
  logic tmr_end;
  assign vel_run = enable && velen;
  assign tmr_end = vel_run && (tmr_r >= period_r - 32'h1);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tmr_r    <= '0;
      velacc_r <= '0;
      velcap_r <= '0;
      div_r    <= '0;
    end else if (ce_i) begin
      if (!vel_run) begin
        // disabled velocity logic restarts cleanly
        tmr_r    <= '0;
        velacc_r <= '0;
        div_r    <= '0;
      end else begin
        if (step) begin
          div_r <= div_r + 7'h01;
        end
        if (tmr_end) begin
          tmr_r    <= '0;
          velcap_r <= velacc_r + VW'(vel_pulse);
          velacc_r <= '0;
        end else begin
          tmr_r    <= tmr_r + 32'h1;
          velacc_r <= velacc_r + VW'(vel_pulse);
        end
      end
    end
  end

  // sticky events; a set in the clear cycle survives
  logic [NE-1:0] ev_set;
  logic [NE-1:0] ev_clr;
  always_comb begin
    ev_set = '0;
    ev_set[qenc_pkg::EV_INDEX] = idx_rise;
    ev_set[qenc_pkg::EV_TIMER] = tmr_end;
    ev_set[qenc_pkg::EV_DIR]   = step && (fwd != dir_r);
    ev_set[qenc_pkg::EV_ERROR] = perr;
    ev_clr = '0;
    if (wr && wb_adr_i == qenc_pkg::OFS_INTCLR && wb_sel_i[0]) begin
      ev_clr = wb_dat_i[NE-1:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      raw_r <= '0;
    end else if (ce_i) begin
      raw_r <= (raw_r & ~ev_clr) | ev_set;
    end
  end

  // readback mux; unmapped offsets read zero and still ack
  // the write-only clear register reads zero through the default arm
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0;
    unique case (wb_adr_i)
      qenc_pkg::OFS_CTRL:    rd = {21'h0, ctrl_r};
      qenc_pkg::OFS_STATUS:  rd = {30'h0, err_r, dir_r};
      qenc_pkg::OFS_POS:     rd = pos_r;
      qenc_pkg::OFS_MAXPOS:  rd = maxpos_r;
      qenc_pkg::OFS_PERIOD:  rd = period_r;
      qenc_pkg::OFS_VELACC:  rd = velacc_r;
      qenc_pkg::OFS_VELCAP:  rd = velcap_r;
      qenc_pkg::OFS_RAWINT:  rd = {28'h0, raw_r};
      qenc_pkg::OFS_INTMASK: rd = {28'h0, mask_r};
      qenc_pkg::OFS_MSKINT:  rd = {28'h0, raw_r & mask_r};
      default:               rd = 32'h0;
    endcase
  end

  // bus answer registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= acc;
      wb_dat_o <= (acc && !wb_we_i) ? rd : 32'h0;
    end
  end

  // outputs from flops; interrupt lags raw status one cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
      dir_o <= 1'b1;
      err_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(raw_r & mask_r);
      dir_o <= dir_r;
      err_o <= err_r;
    end
  end
endmodule
`default_nettype wire

/* test/qenc_properties.sv */
// qenc_properties: port-level checks of the encoder core
`default_nettype none
module qenc_properties (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        phase_input_first_i,
  input wire logic        phase_input_second_i,
  input wire logic        index_i,
  input wire logic        dir_o,
  input wire logic        err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic [2:0] pins = {phase_input_first_i, phase_input_second_i,
                           index_i};
  logic      [2:0] pins_r;
  logic      [3:0] quiet_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // cycles since a pin moved; decode latency stays well under ten
  always_ff @(posedge clk_i) begin
    pins_r <= pins;
    if (!rst_n_i || pins_r != pins)
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hf)
      quiet_r <= quiet_r + 4'h1;
  end
  ack_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not answered");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  dir_hold_a:
    assert property (quiet_r >= 4'ha |-> $stable(dir_o))
    else $error("direction moved while stopped");
  err_cause_a:
    assert property ($rose(err_o) |-> quiet_r < 4'ha)
    else $error("error without pin activity");
  err_sticky_a:
    assert property ($fell(err_o) |-> $past(wb_we_i) || $past(wb_we_i, 2)
      || $past(wb_we_i, 3)) else $error("error dropped on its own");
  reset_out_a:
    assert property ($rose(rst_n_i) |-> dir_o && !err_o && !wb_ack_o)
    else $error("bad outputs after reset");
endmodule
bind qenc_core qenc_properties u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .index_i(index_i),
  .phase_input_first_i(phase_input_first_i), .dir_o(dir_o), .err_o(err_o),
  .phase_input_second_i(phase_input_second_i));
`default_nettype wire

/* test/qenc_enc_model.sv */
// qenc_enc_model: incremental encoder with phase, step and index lines
`default_nettype none
module qenc_enc_model (
  input  wire logic clk_i,
  output logic      first_o,
  output logic      second_o,
  output logic      index_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph_r = 2'h0;
  // lines start low, as a stopped encoder at phase zero
  initial begin
    first_o = 1'b0;
    second_o = 1'b0;
    index_o = 1'b0;
  end
  // d=1 forward, 3 reverse, 2 flips both lines at once (fault)
  task automatic move(input logic [1:0] d);
    repeat (6) @(posedge clk_i);
    ph_r = ph_r + d;
    first_o <= ph_r[1] ^ ph_r[0];
    second_o <= ph_r[1];
  endtask
  // direction level settles long before the step edge
  task automatic step(input logic fwd);
    @(posedge clk_i);
    second_o <= fwd;
    repeat (6) @(posedge clk_i);
    first_o <= !first_o;
  endtask
  // index pulse wide enough to survive the pin filter
  task automatic pulse_index();
    repeat (6) @(posedge clk_i);
    index_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    index_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/qenc_tb_top.sv */
// quadrature_encoder_position_velocity_tb_top: self-checking bench
`default_nettype none
module quadrature_encoder_position_velocity_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cyc = 1'b0;
  logic        ce = 1'b1;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, dat_o, p;
  logic        ack_o, first, second, index, irq_o, dir_o, err_o;
  int          miscompares = 0;
  int          check_count = 0;
  int          seed = 32'h0d24763a;
  int          k;
  always #12.5 clk_i = ~clk_i;
  qenc_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
    .phase_input_first_i(first), .phase_input_second_i(second),
    .index_i(index), .irq_o(irq_o), .dir_o(dir_o), .err_o(err_o));
  qenc_enc_model enc (.clk_i(clk_i), .first_o(first), .second_o(second),
    .index_o(index));
  // request held until the edge that samples ack, then a free cycle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic cfg(input logic [31:0] d);
    bus(1'b1, qenc_pkg::OFS_CTRL, d);
  endtask
  // pins need several cycles to reach the counters
  task automatic go(input logic [1:0] d, input int n);
    repeat (n) enc.move(d);
    repeat (12) @(posedge clk_i);
  endtask
  // wait for a fresh period end, so counts fall in one period
  task automatic sync();
    bus(1'b1, qenc_pkg::OFS_INTCLR, 32'h2);
    do bus(1'b0, qenc_pkg::OFS_RAWINT, 32'h0); while (rdat[1] !== 1'b1);
  endtask
  // position after n signed counts from p, wrapping at the limit mx
  function automatic logic [31:0] walk(input logic [31:0] p, mx,
                                       input int n);
    for (int i = 0; i < (n < 0 ? -n : n); i++)
      if (n > 0) p = (p == mx) ? 32'h0 : p + 32'h1;
      else p = (p == 32'h0) ? mx : p - 32'h1;
    return p;
  endfunction
  task automatic end_sim();
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, several times the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdchk("ctrl", qenc_pkg::OFS_CTRL, 32'h0);
    rdchk("max", qenc_pkg::OFS_MAXPOS, qenc_pkg::MAXPOS_RST);
    rdchk("unmapped", 8'hfc, 32'h0);
    // phase mode, first channel then both, random start and length
    for (int m = 0; m < 2; m++) begin
      p = $random(seed);
      k = 1 + ($random(seed) & 7);
      cfg(m ? 32'h2 : 32'h0);
      cfg(m ? 32'h3 : 32'h1);
      bus(1'b1, qenc_pkg::OFS_POS, p);
      go(2'h1, 2 * k);
      rdchk("pos", qenc_pkg::OFS_POS, walk(p, '1, k << m));
    end
    // reverse through zero wraps to the limit, then swap flips sense
    bus(1'b1, qenc_pkg::OFS_MAXPOS, 32'h64);
    bus(1'b1, qenc_pkg::OFS_POS, 32'h1);
    go(2'h3, 4);
    rdchk("wrap", qenc_pkg::OFS_POS, walk(1, 32'h64, -4));
    chk("dir", 32'h0, {31'h0, dir_o});
    cfg(32'h13);
    go(2'h1, 4);
    rdchk("swap", qenc_pkg::OFS_POS, walk(1, 32'h64, -8));
    // index ignored without reset, loads limit or zero with it
    enc.pulse_index();
    rdchk("norst", qenc_pkg::OFS_POS, walk(1, 32'h64, -8));
    cfg(32'h17);
    enc.pulse_index();
    rdchk("idxrev", qenc_pkg::OFS_POS, 32'h64);
    cfg(32'h07);
    go(2'h1, 2);
    enc.pulse_index();
    rdchk("idxfwd", qenc_pkg::OFS_POS, 32'h0);
    // clear only index; mask decides whether direction reaches irq
    bus(1'b0, qenc_pkg::OFS_RAWINT, 32'h0);
    chk("raw", 32'h5, rdat & 32'h5);
    bus(1'b1, qenc_pkg::OFS_INTCLR, 32'h1);
    bus(1'b0, qenc_pkg::OFS_RAWINT, 32'h0);
    chk("clr", 32'h4, rdat & 32'h5);
    bus(1'b1, qenc_pkg::OFS_INTMASK, 32'h0);
    chk("irqoff", 32'h0, {31'h0, irq_o});
    bus(1'b1, qenc_pkg::OFS_INTMASK, 32'h4);
    chk("irqon", 32'h1, {31'h0, irq_o});
    bus(1'b1, qenc_pkg::OFS_INTCLR, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irqclr", 32'h0, {31'h0, irq_o});
    // velocity over an odd period for prescale ratios 1 to 128
    bus(1'b1, qenc_pkg::OFS_PERIOD, 32'h191);
    for (int d = 0; d < 8; d++) begin
      cfg(32'h23 | (d << 8));
      sync();
      go(2'h1, 8);
      rdchk("vacc", qenc_pkg::OFS_VELACC, 8 >> d);
      sync();
      rdchk("vcap", qenc_pkg::OFS_VELCAP, 8 >> d);
    end
    // disabled unit neither decodes nor accumulates
    cfg(32'h20);
    bus(1'b0, qenc_pkg::OFS_POS, 32'h0);
    p = rdat;
    go(2'h1, 4);
    rdchk("dispos", qenc_pkg::OFS_POS, p);
    rdchk("disvel", qenc_pkg::OFS_VELACC, 32'h0);
    // both lines in one instant give a sticky error
    cfg(32'h01);
    go(2'h2, 1);
    chk("err", 32'h1, {31'h0, err_o});
    bus(1'b0, qenc_pkg::OFS_RAWINT, 32'h0);
    chk("everr", 32'h8, rdat & 32'h8);
    cfg(32'h00);
    // flag clears one cycle after enable drops, output one more
    repeat (2) @(posedge clk_i);
    chk("errclr", 32'h0, {31'h0, err_o});
    // step/direction: each step edge counts, direction level signs it
    cfg(32'h08);
    cfg(32'h09);
    bus(1'b1, qenc_pkg::OFS_POS, 32'h5);
    repeat (3) enc.step(1'b1);
    enc.step(1'b0);
    repeat (12) @(posedge clk_i);
    rdchk("step", qenc_pkg::OFS_POS, 32'h7);
    // a frozen clock enable holds off the bus until it returns
    ce <= 1'b0;
    fork
      bus(1'b1, qenc_pkg::OFS_POS, 32'h0);
      begin
        repeat (6) @(posedge clk_i);
        chk("frozen", 32'h0, {31'h0, ack_o});
        ce <= 1'b1;
      end
    join
    rdchk("thaw", qenc_pkg::OFS_POS, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
